// [inc/tfg_pkg.sv]
// Package for the Ethernet test frame generator: register map, fields, timing.
package tfg_pkg;
	// Register indices; printed offsets are not multiples of four, byte address is index * 4
	localparam logic [7:0] IDX_CONTROL = 8'h1D;
	localparam logic [7:0] IDX_PATTERN = 8'h1E;
	localparam logic [7:0] IDX_STATUS = 8'h1F;
	localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
	localparam logic [9:0] ADDR_PATTERN = {IDX_PATTERN, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	// Control register fields
	localparam int BIT_ENABLE = 15;
	localparam int BIT_RUN = 14;
	localparam int BIT_CONT = 13;
	localparam int LEN_HI = 12;
	localparam int LEN_LO = 11;
	localparam int BIT_GAP = 10;
	localparam int DA_HI = 9;
	localparam int DA_LO = 6;
	localparam int SA_HI = 5;
	localparam int SA_LO = 2;
	localparam int BIT_RANDOM = 1;
	localparam int BIT_BADFCS = 0;
	localparam logic [15:0] CONTROL_RESET = 16'h0040;
	localparam logic [15:0] PATTERN_RESET = 16'h0000;

	// Frame lengths in bytes, destination to FCS inclusive
	localparam logic [13:0] LEN_SEL0 = 14'd125;
	localparam logic [13:0] LEN_SEL1 = 14'd64;
	localparam logic [13:0] LEN_SEL2 = 14'd1518;
	localparam logic [13:0] LEN_SEL3 = 14'd10000;
	localparam logic [15:0] ETHER_TYPE = 16'h88B5;

	// Frame counts
	localparam int FIXED_FRAMES = 30000000;
	localparam int BLOCK_FRAMES = 10000;

	// Timing, one byte per clock at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int GAP_SHORT_NS = 96;
	localparam int GAP_LONG_NS = 8192;
	localparam int GAP_SHORT_CYC = (GAP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_LONG_CYC = (GAP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0] SFD_BYTE = 8'hD5;
	localparam int PREAMBLE_LEN = 7;

	// Settings latched at each start
	typedef struct packed {
		logic cont;
		logic [1:0] len_sel;
		logic gap_long;
		logic [3:0] da_nib;
		logic [3:0] sa_nib;
		logic random;
		logic bad_fcs;
		logic [15:0] pattern;
	} tfg_cfg_t;

	// Byte on the line side
	typedef struct packed {
		logic [7:0] data;
		logic sof;
		logic eof;
	} tfg_byte_t;
endpackage

// [rtl/tfg_crc32.sv]
`timescale 1ns/1ns
// Ethernet CRC-32 accumulator, one byte per cycle.
module tfg_crc32 (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic step,
	input wire logic [7:0] data,
	output logic [31:0] fcs
);
	logic [31:0] crc_q;
	logic [31:0] crc_d;

	always_comb begin
		crc_d = crc_q;
		for (int i = 0; i < 8; i++) begin
			if (crc_d[0] ^ data[i]) begin
				crc_d = (crc_d >> 1) ^ 32'hEDB88320;
			end else begin
				crc_d = crc_d >> 1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || clear) begin
			crc_q <= 32'hFFFFFFFF;
		end else if (step) begin
			crc_q <= crc_d;
		end
	end

	assign fcs = ~crc_q;
endmodule

// [rtl/tfg_fifo.sv]
`timescale 1ns/1ns
// Synchronous FIFO with valid and ready on both sides.
module tfg_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
			$error("tfg_fifo: DEPTH must be a power of two >= 2");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// [rtl/tfg_gen.sv]
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
// Ethernet test frame generator with APB register access and a line-side byte stream.
// Notes on behaviour
// - Frames are produced only while enable and run bits are both one.
// - Duration zero sends 30,000,000 frames then stops; one runs in 10,000 blocks.
// - Leaving continuous mode finishes up to the next multiple of 10,000 frames.
// - Length field picks 125, 64, 1518 or 10,000 byte frames.
// - Gap between frames is 96 ns, or 8,192 ns with gap bit set.
// - Destination address is all ones with low nibble from bits 9:6.
// - Source address is all ones with low nibble from bits 5:2.
// - Payload type one gives a random payload, zero the fixed pattern.
// - Bad-checksum bit makes every frame carry a wrong FCS.
// - Control changes while running, other than clearing the continuous bit, apply only after run is cleared and set.
// - Fixed payload repeats the 16-bit pattern register.
// - Pattern changes while running apply only after a run restart.
module tfg_gen #(
	parameter int FIXED_FRAMES = tfg_pkg::FIXED_FRAMES,
	parameter int BLOCK_FRAMES = tfg_pkg::BLOCK_FRAMES,
	parameter int GAP_LONG_CYC = tfg_pkg::GAP_LONG_CYC,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic tx_sof,
	output logic tx_eof,
	input wire logic tx_ready,
	output logic busy
);
	initial begin
		if (FIXED_FRAMES < 1 || BLOCK_FRAMES < 1 || GAP_LONG_CYC < tfg_pkg::GAP_SHORT_CYC
			|| GAP_LONG_CYC > 16384) begin
			$error("tfg_gen: bad count parameters");
		end
	end

	typedef enum logic [2:0] {
		TFG_IDLE, TFG_PRE, TFG_BODY, TFG_FCS, TFG_GAP
	} tfg_state_t;

	logic [15:0] ctrl_q;
	logic [15:0] pat_q;
	tfg_pkg::tfg_cfg_t cfg_q;
	tfg_state_t state_q;
	logic [31:0] frames_q;
	logic [13:0] pos_q;
	logic [13:0] len_q;
	logic [13:0] gap_q;
	logic [31:0] lfsr_q;
	logic cont_live;
	logic go;
	logic stop_pend_q;
	logic active;
	logic start;
	logic wr;
	logic rd;
	logic [15:0] wval;
	tfg_pkg::tfg_byte_t push_byte;
	tfg_pkg::tfg_byte_t pop_byte;
	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic step;
	logic [7:0] body_byte;
	logic [31:0] fcs;
	logic [7:0] fcs_byte;
	logic [7:0] pay_byte;

	// APB slave, zero wait states
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign wval = pwdata[15:0];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_q <= tfg_pkg::CONTROL_RESET;
			pat_q <= tfg_pkg::PATTERN_RESET;
		end else if (wr && paddr[9:0] == tfg_pkg::ADDR_CONTROL && paddr[11:10] == 2'b00) begin
			ctrl_q <= wval;
		end else if (wr && paddr[9:0] == tfg_pkg::ADDR_PATTERN && paddr[11:10] == 2'b00) begin
			pat_q <= wval;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= '0;
				if (paddr[11:10] != 2'b00) begin
					pslverr <= 1'b1;
				end else if (paddr[9:0] == tfg_pkg::ADDR_CONTROL) begin
					prdata <= {16'h0000, ctrl_q};
				end else if (paddr[9:0] == tfg_pkg::ADDR_PATTERN) begin
					prdata <= {16'h0000, pat_q};
				end else if (paddr[9:0] == tfg_pkg::ADDR_STATUS) begin
					prdata <= frames_q;
				end else begin
					pslverr <= 1'b1;
				end
				if (!rd && paddr[11:10] == 2'b00) begin
					prdata <= '0;
				end
			end
		end
	end

	// Run is armed by a write that sets enable and run while they were not both set
	assign active = ctrl_q[tfg_pkg::BIT_ENABLE] && ctrl_q[tfg_pkg::BIT_RUN];
	assign start = wr && paddr == {2'b00, tfg_pkg::ADDR_CONTROL}
		&& wval[tfg_pkg::BIT_ENABLE] && wval[tfg_pkg::BIT_RUN]
		&& !(ctrl_q[tfg_pkg::BIT_ENABLE] && ctrl_q[tfg_pkg::BIT_RUN]);
	assign cont_live = ctrl_q[tfg_pkg::BIT_CONT];
	// Another frame will follow: running and neither the count nor a block edge stop applies
	assign go = active && !(!cfg_q.cont && frames_q >= 32'(FIXED_FRAMES))
		&& !(stop_pend_q && frames_q % 32'(BLOCK_FRAMES) == 32'h00000000);

	// Snapshot of settings taken only at a start
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_q <= '0;
		end else if (start) begin
			cfg_q.cont <= wval[tfg_pkg::BIT_CONT];
			cfg_q.len_sel <= wval[tfg_pkg::LEN_HI:tfg_pkg::LEN_LO];
			cfg_q.gap_long <= wval[tfg_pkg::BIT_GAP];
			cfg_q.da_nib <= wval[tfg_pkg::DA_HI:tfg_pkg::DA_LO];
			cfg_q.sa_nib <= wval[tfg_pkg::SA_HI:tfg_pkg::SA_LO];
			cfg_q.random <= wval[tfg_pkg::BIT_RANDOM];
			cfg_q.bad_fcs <= wval[tfg_pkg::BIT_BADFCS];
			cfg_q.pattern <= pat_q;
		end
	end

	// Continuous bit is watched live so that turning it off ends the run at a block edge
	always_ff @(posedge clk) begin
		if (!rst_b || start) begin
			stop_pend_q <= 1'b0;
		end else begin
			if (cfg_q.cont && !cont_live) begin
				stop_pend_q <= 1'b1;
			end
		end
	end

	always_comb begin
		case (cfg_q.len_sel)
			2'b00: len_q = tfg_pkg::LEN_SEL0;
			2'b01: len_q = tfg_pkg::LEN_SEL1;
			2'b10: len_q = tfg_pkg::LEN_SEL2;
			default: len_q = tfg_pkg::LEN_SEL3;
		endcase
	end

	// Frame bytes in order: DA, SA, type, payload
	assign pay_byte = cfg_q.random ? lfsr_q[7:0]
		: (pos_q[0] ? cfg_q.pattern[7:0] : cfg_q.pattern[15:8]);
	always_comb begin
		if (pos_q < 14'd5) begin
			body_byte = 8'hFF;
		end else if (pos_q == 14'd5) begin
			body_byte = {4'hF, cfg_q.da_nib};
		end else if (pos_q < 14'd11) begin
			body_byte = 8'hFF;
		end else if (pos_q == 14'd11) begin
			body_byte = {4'hF, cfg_q.sa_nib};
		end else if (pos_q == 14'd12) begin
			body_byte = tfg_pkg::ETHER_TYPE[15:8];
		end else if (pos_q == 14'd13) begin
			body_byte = tfg_pkg::ETHER_TYPE[7:0];
		end else begin
			body_byte = pay_byte;
		end
	end

	// Bad frames carry the inverted CRC
	always_comb begin
		case (pos_q[1:0])
			2'd0: fcs_byte = fcs[7:0];
			2'd1: fcs_byte = fcs[15:8];
			2'd2: fcs_byte = fcs[23:16];
			default: fcs_byte = fcs[31:24];
		endcase
		if (cfg_q.bad_fcs) begin
			fcs_byte = ~fcs_byte;
		end
	end

	always_comb begin
		push_byte = '0;
		push_valid = 1'b0;
		case (state_q)
			TFG_PRE: begin
				push_valid = 1'b1;
				push_byte.data = (pos_q == 14'(tfg_pkg::PREAMBLE_LEN)) ? tfg_pkg::SFD_BYTE
					: tfg_pkg::PREAMBLE_BYTE;
				push_byte.sof = pos_q == 14'd0;
			end
			TFG_BODY: begin
				push_valid = 1'b1;
				push_byte.data = body_byte;
			end
			TFG_FCS: begin
				push_valid = 1'b1;
				push_byte.data = fcs_byte;
				push_byte.eof = pos_q[1:0] == 2'd3;
			end
			default: begin
				push_valid = 1'b0;
			end
		endcase
	end

	assign step = push_valid && push_ready;

	tfg_crc32 u_crc (
		.clk(clk),
		.rst_b(rst_b),
		.clear(state_q == TFG_PRE),
		.step(step && state_q == TFG_BODY),
		.data(body_byte),
		.fcs(fcs)
	);

	// Frame sequencer
	always_ff @(posedge clk) begin
		if (!rst_b || start || !active) begin
			state_q <= TFG_IDLE;
			pos_q <= '0;
			gap_q <= '0;
			frames_q <= (!rst_b || start) ? '0 : frames_q;
		end else begin
			case (state_q)
				TFG_IDLE: begin
					if (!cfg_q.cont && frames_q >= 32'(FIXED_FRAMES)) begin
						state_q <= TFG_IDLE;
					end else if (stop_pend_q && frames_q % 32'(BLOCK_FRAMES) == '0) begin
						state_q <= TFG_IDLE;
					end else begin
						state_q <= TFG_PRE;
						pos_q <= '0;
					end
				end
				TFG_PRE: begin
					if (step) begin
						pos_q <= (pos_q == 14'(tfg_pkg::PREAMBLE_LEN)) ? '0 : pos_q + 14'd1;
						if (pos_q == 14'(tfg_pkg::PREAMBLE_LEN)) begin
							state_q <= TFG_BODY;
						end
					end
				end
				TFG_BODY: begin
					if (step) begin
						pos_q <= (pos_q == len_q - 14'd5) ? '0 : pos_q + 14'd1;
						if (pos_q == len_q - 14'd5) begin
							state_q <= TFG_FCS;
						end
					end
				end
				TFG_FCS: begin
					if (step) begin
						pos_q <= pos_q + 14'd1;
						if (pos_q[1:0] == 2'd3) begin
							state_q <= TFG_GAP;
							frames_q <= frames_q + 32'd1;
							gap_q <= cfg_q.gap_long ? 14'(GAP_LONG_CYC - 1)
								: 14'(tfg_pkg::GAP_SHORT_CYC - 1);
						end
					end
				end
				TFG_GAP: begin
					if (gap_q == '0) begin
						state_q <= TFG_IDLE;
					end else begin
						gap_q <= gap_q - 14'd1;
					end
				end
				default: begin
					state_q <= TFG_IDLE;
				end
			endcase
		end
	end

	// Random payload source
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lfsr_q <= 32'h00000001;
		end else if (step && state_q == TFG_BODY) begin
			lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		end
	end

	tfg_fifo #(
		.WIDTH($bits(tfg_pkg::tfg_byte_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_data(push_byte),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.out_data(pop_byte),
		.out_valid(pop_valid),
		.out_ready(!tx_valid || tx_ready)
	);

	// Registered line-side outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_data <= '0;
			tx_valid <= 1'b0;
			tx_sof <= 1'b0;
			tx_eof <= 1'b0;
			busy <= 1'b0;
		end else begin
			busy <= state_q != TFG_IDLE || go;
			if (!tx_valid || tx_ready) begin
				tx_valid <= pop_valid;
				tx_data <= pop_byte.data;
				tx_sof <= pop_byte.sof && pop_valid;
				tx_eof <= pop_byte.eof && pop_valid;
			end
		end
	end
endmodule

// [dv/tfg_assertions.sv]
`timescale 1ns/1ns
// Port-level checks on the test frame generator.
module tfg_assertions (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_sof,
	input wire logic tx_eof,
	input wire logic tx_ready,
	input wire logic busy
);
	logic [15:0] ctl_q;
	logic [15:0] cfg_q;
	logic [13:0] idx_q;
	logic [13:0] len;
	logic wr;
	logic take;
	logic mid;
	assign wr = psel && penable && pready && pwrite && paddr == 12'(tfg_pkg::ADDR_CONTROL);
	assign take = tx_valid && tx_ready;
	assign mid = take && !tx_sof;
	assign len = cfg_q[12] ? (cfg_q[11] ? tfg_pkg::LEN_SEL3 : tfg_pkg::LEN_SEL2)
		: (cfg_q[11] ? tfg_pkg::LEN_SEL1 : tfg_pkg::LEN_SEL0);
	// Mirror of the control word, and the settings latched at each start
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctl_q <= tfg_pkg::CONTROL_RESET;
			cfg_q <= tfg_pkg::CONTROL_RESET;
		end else if (wr) begin
			ctl_q <= pwdata[15:0];
			if (pwdata[15:14] == 2'b11 && ctl_q[15:14] != 2'b11) begin
				cfg_q <= pwdata[15:0];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			idx_q <= '0;
		end else if (take) begin
			idx_q <= tx_sof ? 14'd1 : idx_q + 14'd1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	chk_access_ready: assert property (s_access |-> pready)
		else $error("no ready in access cycle");
	chk_unmapped_err: assert property (psel && penable && pready && paddr[11:2] != 10'h01D
		&& paddr[11:2] != 10'h01E && paddr[11:2] != 10'h01F |-> pslverr && (pwrite || prdata == '0))
		else $error("unmapped access not refused");
	chk_stop_idle: assert property ((ctl_q[15:14] != 2'b11) [*3] |-> !busy)
		else $error("busy while stopped");
	chk_sof_preamble: assert property (take && tx_sof |-> tx_data == tfg_pkg::PREAMBLE_BYTE)
		else $error("frame does not open with preamble");
	chk_preamble_sfd: assert property (mid && idx_q <= 7 |-> tx_data == (idx_q == 7 ?
		tfg_pkg::SFD_BYTE : tfg_pkg::PREAMBLE_BYTE))
		else $error("bad preamble or delimiter");
	chk_dest_addr: assert property (mid && idx_q inside {[8:13]} |->
		tx_data == (idx_q == 13 ? {4'hF, cfg_q[9:6]} : 8'hFF))
		else $error("bad destination byte");
	chk_src_addr: assert property (mid && idx_q inside {[14:19]} |->
		tx_data == (idx_q == 19 ? {4'hF, cfg_q[5:2]} : 8'hFF))
		else $error("bad source byte");
	chk_eof_len: assert property (take && tx_eof |-> !tx_sof && idx_q == len + 14'd7)
		else $error("frame length wrong");
	chk_valid_hold: assert property (s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_eof))
		else $error("line byte dropped while stalled");
endmodule
bind tfg_gen tfg_assertions u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .tx_data, .tx_valid, .tx_sof, .tx_eof, .tx_ready, .busy);

// [dv/tfg_sink.sv]
`timescale 1ns/1ns
// Line-side receiver that takes bytes, stalling at random when asked.
module tfg_sink (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic stall,
	output logic tx_ready
);
	// Isolated bench link only, never a live network
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= !stall || ($urandom % 3 == 0);
		end
	end
endmodule

// [dv/tfg_gen_bench.sv]
`timescale 1ns/1ns
// Self-checking bench for the test frame generator.
module ethernet_test_packet_generator_bench;
	localparam logic [11:0] A_CTL = 12'h074;
	localparam logic [11:0] A_PAT = 12'h078;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_sof;
	logic tx_eof;
	logic tx_ready;
	logic busy;
	logic stall = 1'b0;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int nfr = 0;
	int eof_cyc = -1;
	int gap_exp = 0;
	int lens[4] = '{125, 64, 1518, 10000};
	logic [7:0] fr[$];
	logic [15:0] ex_ctl;
	logic [15:0] ex_pat;
	logic [15:0] c;
	logic [31:0] rd;
	logic er;
	always #5 clk = ~clk;
	tfg_gen #(.FIXED_FRAMES(20), .BLOCK_FRAMES(5), .GAP_LONG_CYC(40)) dut (.clk, .rst_b,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.tx_data, .tx_valid, .tx_sof, .tx_eof, .tx_ready, .busy);
	tfg_sink u_sink (.clk, .rst_b, .stall, .tx_ready);
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] crc8(input logic [31:0] x, input logic [7:0] d);
		x = x ^ {24'h0, d};
		for (int b = 0; b < 8; b++) begin
			x = x[0] ? (x >> 1) ^ 32'hEDB88320 : x >> 1;
		end
		return x;
	endfunction
	task automatic check_frame();
		logic [31:0] x;
		logic [7:0] e;
		int n;
		n = fr.size();
		x = 32'hFFFFFFFF;
		cmp("frame_len", 32'(lens[ex_ctl[12:11]] + 8), 32'(n));
		for (int i = 0; i < n - 4; i++) begin
			e = i < 7 ? 8'h55 : i == 7 ? 8'hD5 : i == 13 ? {4'hF, ex_ctl[9:6]}
				: i == 19 ? {4'hF, ex_ctl[5:2]} : i < 20 ? 8'hFF : i == 20 ? 8'h88
				: i == 21 ? 8'hB5 : i[0] ? ex_pat[7:0] : ex_pat[15:8];
			if (i < 22 || !ex_ctl[1]) cmp("byte", 32'(e), 32'(fr[i]));
			if (i > 7) x = crc8(x, fr[i]);
		end
		cmp("fcs", ex_ctl[0] ? x : ~x, {fr[n-1], fr[n-2], fr[n-3], fr[n-4]});
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_count++;
			print_verdict();
		end
	end
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			if (tx_sof) begin
				fr.delete();
				if (gap_exp > 0 && eof_cyc >= 0) begin
					cmp("gap", 1, 32'(cyc - eof_cyc > gap_exp && cyc - eof_cyc <= gap_exp + 4));
				end
			end
			fr.push_back(tx_data);
			if (tx_eof) begin
				check_frame();
				nfr++;
				eof_cyc = cyc;
			end
		end
	end
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic start(input logic [15:0] v);
		apb(A_CTL, 1'b1, {16'h0, v & 16'hBFFF});
		apb(A_CTL, 1'b1, {16'h0, v});
		ex_ctl = v;
		nfr = 0;
		eof_cyc = -1;
	endtask
	task automatic wait_idle(input int k);
		while (nfr < k) @(posedge clk);
		while (busy !== 1'b0 || tx_valid !== 1'b0) @(posedge clk);
		repeat (100) @(posedge clk);
	endtask
	initial begin
		void'($urandom(32'h0C63));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		apb(A_CTL, 1'b0, '0);
		cmp("ctl_reset", 32'h0040, rd);
		apb(A_PAT, 1'b0, '0);
		cmp("pat_reset", '0, rd);
		apb(12'h000, 1'b1, 32'h1234);
		cmp("unmapped_err", 1, 32'(er));
		apb(A_CTL, 1'b1, 32'h4000);
		repeat (40) @(posedge clk);
		cmp("run_only_idle", 0, {30'h0, busy, tx_valid});
		$display("test reset done");
		ex_pat = 16'($urandom);
		apb(A_PAT, 1'b1, {16'h0, ex_pat});
		gap_exp = 10;
		start(16'hC800 | (16'($urandom) & 16'h03FC));
		while (nfr < 2) @(posedge clk);
		apb(A_PAT, 1'b1, {16'h0, ~ex_pat});
		apb(A_CTL, 1'b1, {16'h0, ex_ctl ^ 16'h03FD});
		wait_idle(20);
		cmp("fixed_count", 20, 32'(nfr));
		apb(12'h07C, 1'b0, '0);
		cmp("status", 20, rd);
		$display("test fixed run done");
		ex_pat = ~ex_pat;
		gap_exp = 40;
		c = 16'hE403 | (16'($urandom) & 16'h03FC);
		start(c);
		while (nfr < 7) @(posedge clk);
		apb(A_CTL, 1'b1, {16'h0, c & 16'hDFFF});
		wait_idle(0);
		cmp("block_stop", 10, 32'(nfr));
		$display("test continuous done");
		gap_exp = 0;
		stall <= 1'b1;
		for (int l = 2; l < 4; l++) begin
			start(16'hC000 | 16'(l << 11));
			while (nfr < 1) @(posedge clk);
			apb(A_CTL, 1'b1, '0);
			wait_idle(0);
		end
		$display("test long frames done");
		print_verdict();
	end
endmodule
